// ===== logic/exec_defs.vh
// offsets, field positions, encodings and reset values for the status word / lock / string unit
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// ==========================================================================
// register byte offsets on the bus
`define OFS_CMD      8'h00
`define OFS_MCR      8'h04
`define OFS_MODE     8'h08
`define OFS_SIDX     8'h0C
`define OFS_CNT      8'h10
`define OFS_ACC      8'h14
`define OFS_DBASE    8'h18
`define OFS_OBASE    8'h1C
`define OFS_STATUS   8'h20

// ==========================================================================
// command word fields
`define CMD_OP_HI    2
`define CMD_LOCK     8
`define CMD_REP      9
`define CMD_OPS16    10
`define CMD_ADR16    11
`define CMD_MEMOP    12
`define CMD_SEGOVR   13
`define CMD_SRC_LSB  16

// operation classes in the command op field
`define OP_LOAD_STATUS_WORD_OP      3'h0
`define OP_STRING_LOAD_BYTE_OP     3'h1
`define OP_LODSX     3'h2
`define OP_SWAP      3'h3
`define OP_RMW       3'h4

// ==========================================================================
// mode register fields
`define MODE_CPL_LSB 0
`define MODE_V86     2
`define MODE_DIR     3
`define MODE_NULLSEL 4

// ==========================================================================
// fault flag positions, status positions
`define FLT_GP       0
`define FLT_SS       1
`define FLT_PF       2
`define FLT_UD       3
`define FLT_ECODE    4
`define ST_BUSY      5
`define ST_LOCK      6

// ==========================================================================
// widths, sizes, memory error codes, reset values
`define MSW_BITS     4
`define SZ_BYTE      2'h0
`define SZ_WORD      2'h1
`define SZ_DWORD     2'h2
`define ERR_NONE     2'h0
`define ERR_LIMIT    2'h1
`define ERR_STACK    2'h2
`define ERR_PAGE     2'h3
`define MCR_RESET    32'h00000000

`endif

// ===== logic/index_stepper.v
// source index stepper for string loads
`timescale 1ns/1ps
`include "exec_defs.vh"

module index_stepper
(
    input  wire [31:0] idx,
    input  wire [1:0]  size,
    input  wire        dir,
    input  wire        adr16,
    output wire [31:0] idx_next
);

    // ==========================================================================
    // step of 1, 2 or 4; 16-bit addressing wraps inside the low half
    wire [31:0] step = (size == `SZ_BYTE) ? 32'h00000001 :
                       (size == `SZ_WORD) ? 32'h00000002 : 32'h00000004;
    wire [31:0] sum  = dir ? (idx - step) : (idx + step);

    assign idx_next = adr16 ? {idx[31:16], sum[15:0]} : sum;

endmodule

// ===== logic/fault_encoder.v
// maps memory errors and selector checks onto fault flags
`timescale 1ns/1ps
`include "exec_defs.vh"

module fault_encoder
(
    input  wire [1:0] err,
    input  wire       null_sel,
    input  wire       with_code,
    output wire [4:0] fault
);

    // ==========================================================================
    // limit or null selector give gp, stack limit gives ss, paging gives pf
    wire gp = (err == `ERR_LIMIT) | null_sel;
    wire ss = (err == `ERR_STACK);
    wire pf = (err == `ERR_PAGE);

    // real mode pushes no error code, so the code flag stays low there
    assign fault = {(gp | ss | pf) & with_code, 1'b0, pf, ss, gp};

endmodule

// ===== logic/status_word_lock_string_load_exec.v
// execution unit for status word load, locked read-modify-write and string load
//
// How it works
// - status word load copies source bits 1..3 into control bits 1..3 and ORs source bit 0 into bit 0
// - status word load leaves all higher control bits untouched
// - status word load ignores the operand size
// - source bit 0 set turns on protected mode
// - protected mode flag is sticky, status word load never clears it
// - in protected or v86 mode only privilege 0 may load; else gp zero
// - status word load drains earlier work and stalls later commands
// - protected memory source faults: limit/null gp, stack ss, paging pf
// - real mode limit fault gives gp without error code
// - lock prefix holds the bus lock pin through the whole instruction
// - while locked, this unit alone owns shared memory
// - lock only on memory forms of read-modify-write ops, else undefined
// - swap always asserts the bus lock pin
// - locking holds whatever the operand alignment
// - prefixed instruction still raises its own faults beside undefined
// - opcode ac loads a byte, ad a word or dword by operand size
// - string load reads data segment at 32 or 16-bit index, override allowed
// - index increments when direction is 0, decrements when 1
// - index step is 1, 2 or 4 by element size
// - with iterate prefix the load repeats count times
`timescale 1ns/1ps
`include "exec_defs.vh"

module status_word_lock_string_load_exec
#(
    parameter AW = 8
)
(
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          ce,
    // ahb-lite slave
    input  wire          hsel,
    input  wire [AW-1:0] haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire [2:0]    hsize,
    input  wire [31:0]   hwdata,
    input  wire          hready,
    output reg  [31:0]   hrdata,
    output reg           hreadyout,
    output reg           hresp,
    // shared memory port
    output reg           mem_req,
    output reg           mem_write,
    output reg  [31:0]   mem_addr,
    output reg  [1:0]    mem_size,
    output reg  [31:0]   mem_wdata,
    input  wire          mem_ack,
    input  wire [31:0]   mem_rdata,
    input  wire [1:0]    mem_err,
    output reg           bus_lock_pin,
    // core side
    output reg           pipe_flush,
    output reg  [4:0]    fault_flags
);

    // ==========================================================================
    // one-hot states
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SER  = 4'b0010;
    localparam [3:0] S_RD   = 4'b0100;
    localparam [3:0] S_WR   = 4'b1000;

    reg [3:0]    state_q;
    reg [31:0]   mcr_q;
    reg [4:0]    mode_q;
    reg [31:0]   sidx_q;
    reg [31:0]   cnt_q;
    reg [31:0]   acc_q;
    reg [31:0]   dbase_q;
    reg [31:0]   obase_q;
    reg [31:0]   cmd_q;
    reg          ahb_wr_q;
    reg [AW-1:0] ahb_addr_q;
    reg [4:0]    fault_d;
    reg [31:0]   rd_mux;

    // ==========================================================================
    // bus address phase decode
    wire       ap_valid = hsel & hready & htrans[1];
    wire [AW-1:0] ap_word = {haddr[AW-1:2], 2'b00};
    wire [AW-1:0] dp_word = {ahb_addr_q[AW-1:2], 2'b00};
    wire [7:0]    ap_ofs  = ap_word[7:0];
    wire [7:0]    dp_ofs  = dp_word[7:0];
    wire       wr_any   = ahb_wr_q;

    // ==========================================================================
    // command decode, taken from the write data in the data phase
    wire       is_idle  = state_q[0];
    wire       cmd_go   = wr_any & (dp_ofs == `OFS_CMD) & is_idle;
    wire [2:0] n_op     = hwdata[`CMD_OP_HI:0];
    wire       n_lock   = hwdata[`CMD_LOCK];
    wire       n_memop  = hwdata[`CMD_MEMOP];
    wire       prot     = mcr_q[0];
    wire       v86      = mode_q[`MODE_V86];
    wire [1:0] current_privilege      = mode_q[`MODE_CPL_LSB +: 2];
    wire       with_code = prot | v86;

    // lock is legal only on a memory form of a read-modify-write class
    wire lock_ok  = n_memop & ((n_op == `OP_SWAP) | (n_op == `OP_RMW));
    wire ud_bad   = n_lock & ~lock_ok;
    wire priv_bad = (n_op == `OP_LOAD_STATUS_WORD_OP) & with_code & (current_privilege != 2'h0);
    wire n_mem    = n_memop | (n_op == `OP_STRING_LOAD_BYTE_OP) | (n_op == `OP_LODSX);
    wire null_bad = cmd_go & n_mem & prot & mode_q[`MODE_NULLSEL];

    // fields of the command in flight
    wire [2:0] c_op   = cmd_q[`CMD_OP_HI:0];
    wire       c_rep  = cmd_q[`CMD_REP];
    wire       c_a16  = cmd_q[`CMD_ADR16];
    wire       c_ovr  = cmd_q[`CMD_SEGOVR];

    // element size: operand size matters for ad and rmw, never for ac or load_status_word_op
    wire [1:0] n_size = (n_op == `OP_STRING_LOAD_BYTE_OP) ? `SZ_BYTE :
                        (n_op == `OP_LOAD_STATUS_WORD_OP)  ? `SZ_WORD :
                        hwdata[`CMD_OPS16]  ? `SZ_WORD : `SZ_DWORD;

    // ==========================================================================
    // effective source address: data segment or its override, 16/32-bit index
    wire        a16_sel   = is_idle ? hwdata[`CMD_ADR16] : c_a16;
    wire        ovr_sel   = is_idle ? hwdata[`CMD_SEGOVR] : c_ovr;
    wire [31:0] base_sel  = ovr_sel ? obase_q : dbase_q;
    wire [31:0] idx_next;
    wire [31:0] eff_cur   = a16_sel ? {16'h0000, sidx_q[15:0]} : sidx_q;
    wire [31:0] eff_nxt   = a16_sel ? {16'h0000, idx_next[15:0]} : idx_next;
    wire [31:0] addr_cur  = base_sel + eff_cur;
    wire [31:0] addr_nxt  = base_sel + eff_nxt;

    index_stepper u_step
    (
        .idx      (sidx_q),
        .size     (mem_size),
        .dir      (mode_q[`MODE_DIR]),
        .adr16    (c_a16),
        .idx_next (idx_next)
    );

    // ==========================================================================
    // memory and selector fault mapping
    wire       mem_done = (state_q[2] | state_q[3]) & mem_req & mem_ack;
    wire [1:0] err_in   = mem_done ? mem_err : `ERR_NONE;
    wire       err_hit  = mem_done & (mem_err != `ERR_NONE);
    wire [4:0] mem_flt;

    fault_encoder u_flt
    (
        .err       (err_in),
        .null_sel  (null_bad),
        .with_code (with_code),
        .fault     (mem_flt)
    );

    // ==========================================================================
    // fault flags: set wins over a write-one clear in the same cycle
    wire [4:0] flt_clr = (wr_any & (dp_ofs == `OFS_STATUS)) ? hwdata[4:0] : 5'h00;
    wire       own_gp  = cmd_go & priv_bad;
    always @*
    begin
        fault_d = fault_flags & ~flt_clr;
        fault_d = fault_d | mem_flt;
        // both the lock misuse and the op's own fault may be flagged
        if (cmd_go & ud_bad)
            fault_d[`FLT_UD] = 1'b1;
        if (own_gp)
        begin
            fault_d[`FLT_GP]    = 1'b1;
            fault_d[`FLT_ECODE] = 1'b1;
        end
    end

    // ==========================================================================
    // read mux for the register window, unmapped reads give zero
    always @*
    begin
        case (ap_ofs)
            `OFS_CMD:    rd_mux = cmd_q;
            `OFS_MCR:    rd_mux = mcr_q;
            `OFS_MODE:   rd_mux = {27'h0000000, mode_q};
            `OFS_SIDX:   rd_mux = sidx_q;
            `OFS_CNT:    rd_mux = cnt_q;
            `OFS_ACC:    rd_mux = acc_q;
            `OFS_DBASE:  rd_mux = dbase_q;
            `OFS_OBASE:  rd_mux = obase_q;
            `OFS_STATUS: rd_mux = {25'h0000000, bus_lock_pin, ~is_idle, fault_flags};
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // ==========================================================================
    // bus slave: zero wait states, read data registered at the address phase
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= {AW{1'b0}};
        end
        else if (ce)
        begin
            ahb_wr_q   <= ap_valid & hwrite;
            ahb_addr_q <= haddr;
            if (ap_valid & ~hwrite)
                hrdata <= rd_mux;
        end
    end

    // ==========================================================================
    // execution sequencer and architectural registers
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q      <= S_IDLE;
            mcr_q        <= `MCR_RESET;
            mode_q       <= 5'h00;
            sidx_q       <= 32'h00000000;
            cnt_q        <= 32'h00000000;
            acc_q        <= 32'h00000000;
            dbase_q      <= 32'h00000000;
            obase_q      <= 32'h00000000;
            cmd_q        <= 32'h00000000;
            mem_req      <= 1'b0;
            mem_write    <= 1'b0;
            mem_addr     <= 32'h00000000;
            mem_size     <= `SZ_BYTE;
            mem_wdata    <= 32'h00000000;
            bus_lock_pin <= 1'b0;
            pipe_flush   <= 1'b0;
            fault_flags  <= 5'h00;
        end
        else if (ce)
        begin
            pipe_flush  <= 1'b0;
            fault_flags <= fault_d;
            // software writes; the sequencer below overrides while busy
            if (wr_any)
            begin
                case (dp_ofs)
                    `OFS_MCR:   mcr_q[31:`MSW_BITS] <= hwdata[31:`MSW_BITS];
                    `OFS_MODE:  mode_q  <= hwdata[4:0];
                    `OFS_SIDX:  sidx_q  <= hwdata;
                    `OFS_CNT:   cnt_q   <= hwdata;
                    `OFS_ACC:   acc_q   <= hwdata;
                    `OFS_DBASE: dbase_q <= hwdata;
                    `OFS_OBASE: obase_q <= hwdata;
                    default:    mcr_q   <= mcr_q;
                endcase
            end
            case (state_q)
                S_IDLE:
                begin
                    // commands are only taken here, so nothing overtakes a drain
                    if (cmd_go)
                    begin
                        cmd_q    <= hwdata;
                        mem_size <= n_size;
                        mem_addr <= addr_cur;
                        if (~(ud_bad | priv_bad | null_bad))
                        begin
                            case (n_op)
                                `OP_LOAD_STATUS_WORD_OP:
                                begin
                                    state_q    <= S_SER;
                                    pipe_flush <= 1'b1;
                                end
                                `OP_STRING_LOAD_BYTE_OP, `OP_LODSX:
                                begin
                                    // zero count with iterate prefix moves nothing
                                    if (~(hwdata[`CMD_REP] & (cnt_q == 32'h00000000)))
                                    begin
                                        state_q <= S_RD;
                                        mem_req <= 1'b1;
                                    end
                                end
                                `OP_SWAP, `OP_RMW:
                                begin
                                    state_q <= S_RD;
                                    mem_req <= 1'b1;
                                    // one lock span covers split accesses too
                                    bus_lock_pin <= (n_op == `OP_SWAP) | n_lock;
                                end
                                default:
                                    state_q <= S_IDLE;
                            endcase
                        end
                    end
                end
                S_SER:
                begin
                    // earlier work is drained; now either fetch or apply
                    if (cmd_q[`CMD_MEMOP])
                    begin
                        state_q <= S_RD;
                        mem_req <= 1'b1;
                    end
                    else
                    begin
                        mcr_q[3:1] <= cmd_q[`CMD_SRC_LSB+1 +: 3];
                        mcr_q[0]   <= mcr_q[0] | cmd_q[`CMD_SRC_LSB];
                        state_q    <= S_IDLE;
                    end
                end
                S_RD:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        if (err_hit)
                        begin
                            bus_lock_pin <= 1'b0;
                            state_q      <= S_IDLE;
                        end
                        else
                        begin
                            case (c_op)
                                `OP_LOAD_STATUS_WORD_OP:
                                begin
                                    mcr_q[3:1] <= mem_rdata[3:1];
                                    mcr_q[0]   <= mcr_q[0] | mem_rdata[0];
                                    state_q    <= S_IDLE;
                                end
                                `OP_STRING_LOAD_BYTE_OP, `OP_LODSX:
                                begin
                                    if (mem_size == `SZ_BYTE)
                                        acc_q[7:0] <= mem_rdata[7:0];
                                    else if (mem_size == `SZ_WORD)
                                        acc_q[15:0] <= mem_rdata[15:0];
                                    else
                                        acc_q <= mem_rdata;
                                    sidx_q <= idx_next;
                                    if (c_rep)
                                        cnt_q <= cnt_q - 32'h00000001;
                                    // another element while the count lasts
                                    if (c_rep & (cnt_q != 32'h00000001))
                                    begin
                                        mem_req  <= 1'b1;
                                        mem_addr <= addr_nxt;
                                    end
                                    else
                                        state_q <= S_IDLE;
                                end
                                `OP_SWAP:
                                begin
                                    acc_q     <= mem_rdata;
                                    mem_wdata <= acc_q;
                                    mem_write <= 1'b1;
                                    mem_req   <= 1'b1;
                                    state_q   <= S_WR;
                                end
                                default:
                                begin
                                    // bit-set style update of the read value
                                    mem_wdata <= mem_rdata | acc_q;
                                    mem_write <= 1'b1;
                                    mem_req   <= 1'b1;
                                    state_q   <= S_WR;
                                end
                            endcase
                        end
                    end
                end
                S_WR:
                begin
                    if (mem_ack)
                    begin
                        mem_req      <= 1'b0;
                        mem_write    <= 1'b0;
                        bus_lock_pin <= 1'b0;
                        state_q      <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

endmodule

// ===== bench/exec_monitor.sv
// port checker for the execution unit
`timescale 1ns/1ps
module exec_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       mem_req,
    input wire logic       mem_write,
    input wire logic       mem_ack,
    input wire logic [1:0] mem_err,
    input wire logic       bus_lock_pin,
    input wire logic       pipe_flush,
    input wire logic [4:0] fault_flags
);
    default clocking @(posedge clk_sys); endclocking
    // ce low freezes the unit, so nothing is judged then
    default disable iff (rst || !ce);
    // ==========================================
    // locked read then write
    sequence lk_rd;
        bus_lock_pin && mem_req && !mem_write && mem_ack && mem_err == 2'h0;
    endsequence
    sequence lk_wr;
        bus_lock_pin && mem_req && mem_write && mem_ack;
    endsequence
    lock_rmw_a: assert property (lk_rd |=> mem_req && mem_write && bus_lock_pin)
        else $error("no locked write");
    lock_hold_a: assert property (bus_lock_pin && mem_req && !mem_ack |=> bus_lock_pin)
        else $error("lock dropped early");
    lock_free_a: assert property (lk_wr |=> !bus_lock_pin)
        else $error("lock held late");
    lock_err_a: assert property (bus_lock_pin && mem_ack && mem_err != 2'h0 |=> !bus_lock_pin)
        else $error("lock kept on abort");
    // ==========================================
    // serialization and faults
    flush_once_a: assert property (pipe_flush |=> !pipe_flush)
        else $error("flush too long");
    flush_quiet_a: assert property (pipe_flush |-> !mem_req)
        else $error("access while draining");
    gp_limit_a: assert property (mem_req && mem_ack && mem_err == 2'h1 |=> fault_flags[0])
        else $error("limit gp missing");
    ss_limit_a: assert property (mem_req && mem_ack && mem_err == 2'h2 |=> fault_flags[1])
        else $error("stack fault missing");
endmodule

// ===== bench/shared_mem_model.sv
// shared memory agent on the unit's memory port
`timescale 1ns/1ps
module shared_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic [1:0]  mem_size,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [1:0]  err_set,
    output      logic        mem_ack,
    output      logic [31:0] mem_rdata,
    output      logic [1:0]  mem_err
);
    logic [7:0] mem_q [256];
    logic [1:0] wait_q;
    logic       slow_q;
    wire  [7:0] a = mem_addr[7:0];
    // byte i holds i, so expected data follow from the address
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_q[i] = i[7:0];
        {mem_ack, mem_rdata, mem_err, wait_q, slow_q} = '0;
    end
    // every other access waits three cycles; idle data lines churn
    // no other agent exists, so memory stays untouched under lock
    always @(posedge clk_sys)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        mem_err <= ~mem_err;
        if (mem_req && !mem_ack && wait_q >= {slow_q, slow_q})
        begin
            mem_ack <= 1'b1;
            mem_err <= err_set;
            slow_q <= ~slow_q;
            wait_q <= 2'h0;
            mem_rdata <= {mem_q[a + 8'h3], mem_q[a + 8'h2], mem_q[a + 8'h1], mem_q[a]};
            for (int k = 0; k < 4; k++)
                if (mem_write && err_set == 2'h0 && k < (1 << mem_size))
                    mem_q[a + k[7:0]] <= mem_wdata[8*k +: 8];
        end
        else if (mem_req && !mem_ack)
            wait_q <= wait_q + 2'h1;
    end
endmodule

// ===== bench/status_word_lock_string_load_exec_tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module status_word_lock_string_load_exec_tb_top;
    logic        clk_sys, rst, hwrite, hrdy, hresp, mem_req, mem_write, mem_ack;
    logic        bus_lock_pin, pipe_flush, lock_seen;
    logic [7:0]  haddr;
    logic [1:0]  htrans, mem_size, mem_err, err_set;
    logic [31:0] hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [4:0]  fault_flags;
    int          err_total, total_checks, cyc;
    status_word_lock_string_load_exec uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err),
        .bus_lock_pin(bus_lock_pin), .pipe_flush(pipe_flush), .fault_flags(fault_flags));
    shared_mem_model mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .err_set(err_set),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err));
    // ==========================================
    // clock, lock watch and hang limit
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (bus_lock_pin)
            lock_seen <= 1'b1;
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    // ==========================================
    // bus cycles and compares
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd & m);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    // start a command and poll busy, bounded
    task automatic run(input logic [31:0] c);
        bus(1'b1, 8'h00, c);
        rd = 32'h20;
        for (int i = 0; i < 40 && rd[5] !== 1'b0; i++)
            bus(1'b0, 8'h20, 32'h0);
        chk("idle", 32'h0, rd & 32'h20);
    endtask
    task automatic lod(input logic [31:0] md, c, m, a, s);
        bus(1'b1, 8'h08, md);
        run(c);
        rchk("acc", 8'h14, m, a);
        rchk("sidx", 8'h0C, 32'hFFFFFFFF, s);
    endtask
    // command, then lock seen and fault flags; flags cleared after
    task automatic lk(input logic [31:0] c, input logic l, input logic [31:0] f);
        lock_seen <= 1'b0;
        run(c);
        chk("lock", {31'h0, l}, {31'h0, lock_seen});
        rchk("fault", 8'h20, 32'h5F, f);
        bus(1'b1, 8'h20, 32'h1F);
    endtask
    // ==========================================
    // scenarios
    task automatic t_string_load_op();
        bus(1'b1, 8'h18, 32'h40);
        bus(1'b1, 8'h1C, 32'h80);
        bus(1'b1, 8'h0C, 32'h10);
        lod(32'h0, 32'h1001, 32'hFF, 32'h50, 32'h11);
        lod(32'h0, 32'h1402, 32'hFFFF, 32'h5251, 32'h13);
        lod(32'h0, 32'h1002, 32'hFFFFFFFF, 32'h56555453, 32'h17);
        lod(32'h8, 32'h1002, 32'hFFFFFFFF, 32'h5A595857, 32'h13);
        lod(32'h0, 32'h3001, 32'hFF, 32'h93, 32'h14);
        bus(1'b1, 8'h10, 32'h3);
        lod(32'h0, 32'h1201, 32'hFF, 32'h56, 32'h17);
        rchk("count", 8'h10, 32'hFFFFFFFF, 32'h0);
        bus(1'b1, 8'h0C, 32'h1FFFF);
        lod(32'h0, 32'h1801, 32'hFF, 32'h3F, 32'h10000);
    endtask
    task automatic t_lock();
        lk(32'h1003, 1'b1, 32'h0);
        lk(32'h1104, 1'b1, 32'h0);
        lk(32'h1004, 1'b0, 32'h0);
        lk(32'h0104, 1'b0, 32'h08);
        lk(32'h1101, 1'b0, 32'h08);
        err_set <= 2'h1;
        lk(32'h1001, 1'b0, 32'h01);
        err_set <= 2'h3;
        lk(32'h1001, 1'b0, 32'h04);
        err_set <= 2'h2;
        lk(32'h1003, 1'b1, 32'h02);
        err_set <= 2'h0;
    endtask
    task automatic t_load_status_word_op();
        bus(1'b1, 8'h04, 32'hFFFFFFFF);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'hFFFFFFF0);
        run(32'h000F0000);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'hFFFFFFFF);
        run(32'h00060400);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'hFFFFFFF7);
        bus(1'b1, 8'h0C, 32'h8);
        run(32'h00001000);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'hFFFFFFF9);
        bus(1'b1, 8'h08, 32'h3);
        lk(32'h00080000, 1'b0, 32'h11);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'hFFFFFFF9);
        lk(32'h00000100, 1'b0, 32'h19);
        bus(1'b1, 8'h08, 32'h10);
        lk(32'h1001, 1'b0, 32'h11);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {rst, htrans, haddr, hwrite, hwdata, err_set, lock_seen} = '1;
        htrans = 2'h0;
        err_set = 2'h0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rchk("mcr", 8'h04, 32'hFFFFFFFF, 32'h0);
        rchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
        t_string_load_op();
        t_lock();
        t_load_status_word_op();
        summarize();
    end
endmodule
bind status_word_lock_string_load_exec exec_monitor mon (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .mem_req(mem_req), .mem_write(mem_write), .mem_ack(mem_ack), .mem_err(mem_err),
    .bus_lock_pin(bus_lock_pin), .pipe_flush(pipe_flush), .fault_flags(fault_flags));
